/* File: core/ts_cfg.svh */
// offsets, field codes, reset values and timing counts of the timestamp counter
`ifndef TS_CFG_SVH
`define TS_CFG_SVH
// register indices; the byte address is four times the index
`define CMD_IDX 16'hB798
`define TOD_IDX 16'hB7B6
`define DATE_IDX 16'hB7B7
`define LIMIT_IDX 16'hB7C5
`define STATUS_IDX 16'hB7F0
`define CNT_LO_IDX 16'hB7F1
`define CNT_HI_IDX 16'hB7F2
// command register codes
`define CLEAR_BIT 0
`define AWAIT_BIT 3
`define MODE_MASK 32'h0000_00F6
`define CMD_MASK 32'h0000_0009
`define MODE_OFF 8'h00
`define MODE_STD 8'h02
`define MODE_START 8'h04
`define SRC_FULL 4'h1
`define SRC_RISE 4'h2
`define SRC_FALL 4'h4
`define SRC_LSB 8
// reset values
`define CMD_RST 32'h0000_0000
`define LIMIT_RST 32'h0000_03E8
// timing
`define MS_NS 1000000
`define CLK_NS 10
`endif

/* File: core/ts_pkg.sv */
// types shared by the timestamp counter
`default_nettype none
package ts_pkg;
    // wait-for-edge sequencer
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_AWAIT = 2'b01
    } state_t;
    // host wall clock words presented to the block
    typedef struct packed {
        logic [31:0] date;
        logic [31:0] tod;
    } host_clock_t;
    // status bits readable by software
    typedef struct packed {
        logic loaded;
        logic failed;
        logic waiting;
    } status_t;
endpackage : ts_pkg
`default_nettype wire

/* File: core/timestamp_counter_modes.sv */
// timestamp counter with command, start and reference-clock reset modes
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "ts_cfg.svh"
module timestamp_counter_modes
    import ts_pkg::*;
#(
    parameter int CNT_W = 64,
    parameter int LOW_W = 32,
    parameter int MS_CYCLES = `MS_NS / `CLK_NS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [17:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic ref_clk_i,
    input wire logic card_start_i,
    input wire logic clk_running_i,
    input wire host_clock_t host_clock_i,
    output logic [CNT_W-1:0] stamp_o
);
    // ------------------------------------------------------------
    // register bus decode
    // ------------------------------------------------------------
    logic req; // access in progress and not yet answered
    logic wr; // write strobe in the acknowledged cycle
    logic [15:0] idx; // word index of the access
    logic [31:0] cmd_q; // stored mode and source, command bits masked
    logic [31:0] tod_q; // captured time of day
    logic [31:0] date_q; // captured date
    logic [31:0] limit_q; // wait limit in milliseconds
    logic loaded_q; // mode has been written
    logic failed_q; // last edge wait timed out
    state_t state_q; // edge wait sequencer
    logic [CNT_W-1:0] counter_q; // the timestamp counter
    logic [63:0] cnt64; // counter widened for readback
    status_t status; // status word fields

    assign req = cyc_i && stb_i && !ack_o;
    // a write lands at the edge where the master samples ack high
    assign wr = cyc_i && stb_i && we_i && ack_o;
    assign idx = adr_i[17:2];
    assign cnt64 = 64'(counter_q);
    assign status = '{loaded: loaded_q, failed: failed_q, waiting: (state_q == ST_AWAIT)};

    // byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction : merge

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic cmd_wr; // write to the command register
    logic [31:0] cmd_val; // written command word after lane merge
    logic is_cmd; // write carries a reset code
    logic [7:0] mode; // current mode code
    logic [3:0] src; // current source code
    logic split; // split counting selected
    logic ready; // commands may act on the counters
    logic clear_go; // counters are cleared this cycle
    logic await_go; // clear then wait for an edge

    assign cmd_wr = wr && (idx == `CMD_IDX);
    assign cmd_val = merge(cmd_q, dat_i, sel_i);
    assign is_cmd = |(cmd_val & `CMD_MASK);
    assign mode = cmd_q[7:0] & 8'(`MODE_MASK);
    assign src = cmd_q[`SRC_LSB +: 4];
    assign split = (src == `SRC_RISE) || (src == `SRC_FALL);
    assign ready = clk_running_i && loaded_q && (mode == `MODE_STD);
    assign clear_go = cmd_wr && is_cmd && ready && (state_q == ST_IDLE);
    assign await_go = clear_go && cmd_val[`AWAIT_BIT];

    // ------------------------------------------------------------
    // reference clock synchroniser and edge detect
    // ------------------------------------------------------------
    logic ref_meta_q; // first stage, read by the second stage and by AST_SYNC
    logic ref_sync_q; // second stage
    logic ref_old_q; // previous synchronised level
    logic ref_edge; // selected edge seen

    // two flops then one more for the edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_meta_q <= 1'b0;
            ref_sync_q <= 1'b0;
            ref_old_q <= 1'b0;
        end else begin
            ref_meta_q <= ref_clk_i;
            ref_sync_q <= ref_meta_q;
            ref_old_q <= ref_sync_q;
        end
    end

    // falling code picks the falling edge, otherwise rising
    assign ref_edge = (src == `SRC_FALL) ? (ref_old_q && !ref_sync_q)
                                         : (!ref_old_q && ref_sync_q);

    // ------------------------------------------------------------
    // timestamp counter
    // ------------------------------------------------------------
    // clears take priority, then the selected counting scheme
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counter_q <= '0;
        end else if (mode == `MODE_OFF) begin
            counter_q <= '0;
        end else if (clear_go) begin
            counter_q <= '0;
        end else if ((mode == `MODE_START) && card_start_i) begin
            counter_q <= '0;
        end else if (split && ref_edge) begin
            // upper advances, lower restarts the period
            counter_q[CNT_W-1:LOW_W] <= counter_q[CNT_W-1:LOW_W] + 1'b1;
            counter_q[LOW_W-1:0] <= '0;
        end else if (split) begin
            counter_q[LOW_W-1:0] <= counter_q[LOW_W-1:0] + 1'b1;
        end else begin
            counter_q <= counter_q + 1'b1;
        end
    end

    assign stamp_o = counter_q;

    // ------------------------------------------------------------
    // edge wait with millisecond limit
    // ------------------------------------------------------------
    logic [$clog2(MS_CYCLES+1)-1:0] tick_q; // cycles within the current millisecond
    logic [31:0] ms_q; // whole milliseconds waited
    logic expired; // wait limit reached
    logic capture; // store host clock now

    assign expired = (ms_q >= limit_q);
    assign capture = (clear_go && !await_go) || ((state_q == ST_AWAIT) && ref_edge);

    // sequencer and millisecond timer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            tick_q <= '0;
            ms_q <= '0;
            failed_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    tick_q <= '0;
                    ms_q <= '0;
                    if (await_go) begin
                        state_q <= ST_AWAIT;
                        failed_q <= 1'b0;
                    end else if (clear_go) begin
                        failed_q <= 1'b0;
                    end
                end
                ST_AWAIT: begin
                    if (ref_edge) begin
                        state_q <= ST_IDLE;
                    end else if (expired) begin
                        state_q <= ST_IDLE;
                        failed_q <= 1'b1;
                    end else if (32'(tick_q) == MS_CYCLES - 1) begin
                        tick_q <= '0;
                        ms_q <= ms_q + 32'h0000_0001;
                    end else begin
                        tick_q <= tick_q + 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // configuration and captured words
    // ------------------------------------------------------------
    // mode write stores the word, a command write leaves it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_q <= `CMD_RST;
            loaded_q <= 1'b0;
        end else if (cmd_wr && !is_cmd) begin
            cmd_q <= cmd_val & ~`CMD_MASK;
            loaded_q <= 1'b1;
        end
    end

    // captured host words; hardware capture wins over a software write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tod_q <= 32'h0000_0000;
            date_q <= 32'h0000_0000;
        end else if (capture) begin
            tod_q <= {8'h00, host_clock_i.tod[23:0]};
            date_q <= host_clock_i.date;
        end else begin
            if (wr && (idx == `TOD_IDX)) begin
                tod_q <= merge(tod_q, dat_i, sel_i);
            end
            if (wr && (idx == `DATE_IDX)) begin
                date_q <= merge(date_q, dat_i, sel_i);
            end
        end
    end

    // wait limit register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            limit_q <= `LIMIT_RST;
        end else if (wr && (idx == `LIMIT_IDX)) begin
            limit_q <= merge(limit_q, dat_i, sel_i);
        end
    end

    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    // one-cycle ack, read data registered with it, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req;
            dat_o <= 32'h0000_0000;
            if (req && !we_i) begin
                unique case (idx)
                    `CMD_IDX: dat_o <= cmd_q;
                    `TOD_IDX: dat_o <= tod_q;
                    `DATE_IDX: dat_o <= date_q;
                    `LIMIT_IDX: dat_o <= limit_q;
                    `STATUS_IDX: dat_o <= {29'h0, status};
                    `CNT_LO_IDX: dat_o <= cnt64[31:0];
                    `CNT_HI_IDX: dat_o <= cnt64[63:32];
                    default: dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_quiet;
        !clear_go && !(mode == `MODE_START && card_start_i) && mode != `MODE_OFF;
    endsequence
    sequence s_edge_in_wait;
        state_q == ST_AWAIT && ref_edge;
    endsequence

    AST_ACK_ONE: assert property (ack_o |=> !ack_o)
        else $error("ack held two cycles");
    AST_CLEAR: assert property (clear_go |=> counter_q == '0)
        else $error("reset command did not clear");
    AST_START: assert property (mode == `MODE_START && card_start_i |=> counter_q == '0)
        else $error("card start did not clear");
    AST_OFF: assert property (mode == `MODE_OFF |=> counter_q == '0)
        else $error("disabled counter moved");
    AST_FULL: assert property (s_quiet and !split |=> counter_q == $past(counter_q) + 1'b1)
        else $error("full counter missed a cycle");
    AST_SPLIT_EDGE: assert property (s_quiet and split && ref_edge |=>
        counter_q[LOW_W-1:0] == '0 &&
        counter_q[CNT_W-1:LOW_W] == $past(counter_q[CNT_W-1:LOW_W]) + 1'b1)
        else $error("edge did not advance upper part");
    AST_SPLIT_LOW: assert property (s_quiet and split && !ref_edge |=>
        $stable(counter_q[CNT_W-1:LOW_W]))
        else $error("upper part moved without edge");
    AST_CAPTURE: assert property (clear_go && !await_go |=> date_q == $past(host_clock_i.date))
        else $error("date not captured");
    AST_EDGE_DONE: assert property (s_edge_in_wait |=> state_q == ST_IDLE && !failed_q &&
        tod_q[23:0] == $past(host_clock_i.tod[23:0]))
        else $error("edge wait did not capture");
    AST_TIMEOUT: assert property (state_q == ST_AWAIT && expired && !ref_edge |=>
        state_q == ST_IDLE && failed_q)
        else $error("wait limit not enforced");
    // a refused clear leaves a full-width counter running on
    AST_GATE: assert property (cmd_wr && is_cmd && !clk_running_i && mode == `MODE_STD &&
        !split |=> counter_q == $past(counter_q) + 1'b1)
        else $error("command acted without clock");
    // a rise out of the first stage shows as an edge one cycle later
    AST_SYNC: assert property ($rose(ref_meta_q) && src == `SRC_RISE |=> ref_edge)
        else $error("edge not from synchronised level");
endmodule : timestamp_counter_modes
`default_nettype wire

/* File: sim/ref_clock_src.sv */
// reference clock source model for the split counter modes
`timescale 1ns/1ps
`default_nettype none
module ref_clock_src (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic toggle_i,
    output var logic ref_o
);
    // ---------------------------------------------------------------
    // output level
    // ---------------------------------------------------------------
    // level stands still between requests, like a pulse-per-second source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_o <= 1'b0;
        end else if (toggle_i) begin
            ref_o <= ~ref_o;
        end
    end
endmodule : ref_clock_src
`default_nettype wire

/* File: sim/timestamp_counter_modes_tb.sv */
// self-checking bench for the timestamp counter
`timescale 1ns/1ps
`default_nettype none
`include "ts_cfg.svh"
module timestamp_counter_modes_tb;
    import ts_pkg::*;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic clk, rst, cyc, stb, we, tog, card_start, clk_run, ack, ref_clk;
    logic [17:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, rdat, rd;
    logic [63:0] stamp, s0;
    host_clock_t host;
    int mismatches = 0;
    int n_tests = 0;

    timestamp_counter_modes #(.MS_CYCLES(10)) dut_u (.clk_i(clk), .rst_i(rst),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
        .dat_o(rdat), .ack_o(ack), .ref_clk_i(ref_clk), .card_start_i(card_start),
        .clk_running_i(clk_run), .host_clock_i(host), .stamp_o(stamp));
    ref_clock_src ref_u (.clk_i(clk), .rst_i(rst), .toggle_i(tog), .ref_o(ref_clk));

    // sampling clock, one fixed rate for the whole run
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic test_done();
        $display("TB: tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; holds everything until ack is sampled high
    task automatic wb(input logic [15:0] idx, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
        wb(idx, 1'b0, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask : tick

    // one-cycle request pulses
    task automatic edge_req();
        tog <= 1'b1;
        tick(1);
        tog <= 1'b0;
        tick(6);
    endtask : edge_req

    task automatic start_pulse();
        card_start <= 1'b1;
        tick(1);
        card_start <= 1'b0;
    endtask : start_pulse

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        {cyc, stb, we, tog, card_start, clk_run} = '0;
        adr = '0;
        sel = 4'hF;
        dat = '0;
        host = '0;
        rst = 1'b1;
        tick(5);
        rst <= 1'b0;
        tick(1);
        rdchk(`CMD_IDX, `CMD_RST);
        rdchk(`LIMIT_IDX, `LIMIT_RST);
        wb(16'hB700, 1'b1, 32'hFFFF_FFFF);
        rdchk(16'hB700, 32'h0);
        // clear refused while clock generation is off
        wb(`CMD_IDX, 1'b1, 32'h0000_0102);
        tick(20);
        wb(`CMD_IDX, 1'b1, 32'h1);
        chk(32'(stamp > 64'h14), 32'h1);
        clk_run <= 1'b1;
        host <= {32'h07E8_0C1F, 32'hAB17_2B3C};
        wb(`CMD_IDX, 1'b1, 32'h1);
        chk(32'(stamp < 64'h4), 32'h1);
        s0 = stamp;
        start_pulse();
        tick(19);
        chk(32'(stamp - s0), 32'h14);
        rdchk(`TOD_IDX, 32'h0017_2B3C);
        rdchk(`DATE_IDX, 32'h07E8_0C1F);
        // start mode: card start clears, clear command refused
        wb(`CMD_IDX, 1'b1, 32'h0000_0104);
        tick(20);
        start_pulse();
        tick(1);
        chk(32'(stamp < 64'h4), 32'h1);
        tick(20);
        wb(`CMD_IDX, 1'b1, 32'h1);
        chk(32'(stamp > 64'hA), 32'h1);
        wb(`CMD_IDX, 1'b1, 32'h0000_0100);
        tick(3);
        chk(stamp[31:0], 32'h0);
        rdchk(`CNT_LO_IDX, 32'h0);
        // split counting on rising, then falling reference edges
        for (int i = 0; i < 2; i++) begin
            wb(`CMD_IDX, 1'b1, (i == 0) ? 32'h0000_0202 : 32'h0000_0402);
            wb(`CMD_IDX, 1'b1, 32'h1);
            chk(stamp[63:32], 32'h0);
            edge_req();
            chk(stamp[63:32], (i == 0) ? 32'h1 : 32'h0);
            if (i == 0) chk(32'(stamp[31:0] < 32'h8), 32'h1);
            edge_req();
            chk(stamp[63:32], 32'h1);
            rdchk(`CNT_HI_IDX, 32'h1);
        end
        // clear then wait for a rising edge, which arrives in time
        wb(`CMD_IDX, 1'b1, 32'h0000_0202);
        wb(`LIMIT_IDX, 1'b1, 32'h2);
        rdchk(`LIMIT_IDX, 32'h2);
        host <= {32'h07E9_0101, 32'h0001_0203};
        wb(`CMD_IDX, 1'b1, 32'h8);
        rdchk(`STATUS_IDX, 32'h5);
        edge_req();
        rdchk(`STATUS_IDX, 32'h4);
        rdchk(`TOD_IDX, 32'h0001_0203);
        rdchk(`DATE_IDX, 32'h07E9_0101);
        // no edge: the wait gives up once the limit has passed
        wb(`CMD_IDX, 1'b1, 32'h8);
        tick(8);
        rdchk(`STATUS_IDX, 32'h5);
        tick(20);
        rdchk(`STATUS_IDX, 32'h6);
        // software may rewrite the captured time word while idle
        wb(`TOD_IDX, 1'b1, 32'h0012_3456);
        rdchk(`TOD_IDX, 32'h0012_3456);
        // mid-run reset returns counter, limit and status to reset values
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        chk(stamp[31:0], 32'h0);
        rdchk(`LIMIT_IDX, `LIMIT_RST);
        rdchk(`STATUS_IDX, 32'h0);
        test_done();
    end

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        test_done();
    end
endmodule : timestamp_counter_modes_tb
`default_nettype wire
